// *** hdl/apa_seq.sv ***
// Precharge and acquisition sequencer ahead of an analog-to-digital conversion.
// Assumes start inputs are on clk_sys; the converter clock is an enable from apa_clk_div.
`timescale 1ns/100ps
module apa_seq
    import apa_pkg::*;
#(
    parameter int PRE_W = APA_PRE_W,
    parameter int ACQ_W = APA_ACQ_W,
    parameter int DIV_W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Converter clock divider ratio
    input wire logic [DIV_W-1:0] conv_clk_div,
    // Conversion start sources
    input wire logic go_start,
    input wire logic trigger_start,
    input wire logic restart_start,
    // Configuration
    input wire logic [PRE_W-1:0] charge_phase_length,
    input wire logic [ACQ_W-1:0] sampling_window_length,
    input wire logic charge_phase_polarity,
    input wire logic pin_direction_control,
    // Conversion stage handshake
    input wire logic conv_done,
    // Channel pin
    output logic pin_out,
    output logic pin_oe,
    // Hold capacitor switches
    output logic hold_capacitor_to_vdd,
    output logic hold_capacitor_to_vss,
    output logic hold_capacitor_to_channel,
    // Status
    output logic precharge_active,
    output logic acquire_active,
    output logic conv_start,
    output logic busy
);
    initial
    begin
        if (PRE_W < 1 || PRE_W > 16) $error("apa_seq: PRE_W out of range");
        if (ACQ_W != APA_ACQ_W) $error("apa_seq: ACQ_W must match maximum window");
    end

    typedef struct packed {
        apa_state_t state;
        logic [15:0] cnt;
        logic pol;
        logic pin_out;
        logic pin_oe;
        logic cap_vdd;
        logic cap_vss;
        logic cap_chan;
        logic pre_act;
        logic acq_act;
        logic conv_start;
        logic busy;
    } apa_seq_t;

    apa_seq_t cur;
    apa_seq_t next_cur;
    logic tick;
    logic start_req;
    logic [15:0] acq_len;

    // ===========================================================
    // Converter clock enable
    apa_clk_div #(
        .DIV_W(DIV_W)
    ) u_div (
        .clk_sys(clk_sys),
        .srst(srst),
        .div_ratio(conv_clk_div),
        .tick(tick)
    );

    // ===========================================================
    // Acquisition length selection
    function automatic logic [15:0] acq_cycles(input logic [ACQ_W-1:0] len,
                                               input logic pre_on);
        logic [15:0] r;
        r = 16'(len);
        if (len == APA_ACQ_ZERO && pre_on)
            r = 16'(APA_ACQ_MAX);
        return r;
    endfunction : acq_cycles

    assign start_req = go_start | trigger_start | restart_start;
    assign acq_len = acq_cycles(sampling_window_length, charge_phase_length != APA_PRE_ZERO);

    // ===========================================================
    // Sequencer
    always_comb
    begin
        next_cur = cur;
        next_cur.conv_start = 1'b0;
        case (cur.state)
            APA_IDLE:
            begin
                if (start_req)
                begin
                    next_cur.busy = 1'b1;
                    next_cur.pol = charge_phase_polarity;
                    if (charge_phase_length != APA_PRE_ZERO)
                    begin
                        next_cur.state = APA_PRECHARGE;
                        next_cur.cnt = 16'(charge_phase_length);
                        next_cur.pre_act = 1'b1;
                        next_cur.cap_chan = 1'b0;
                        next_cur.cap_vdd = charge_phase_polarity;
                        next_cur.cap_vss = ~charge_phase_polarity;
                        next_cur.pin_out = charge_phase_polarity;
                        next_cur.pin_oe = 1'b1;
                    end
                    else if (acq_len != APA_CNT_ZERO)
                    begin
                        next_cur.state = APA_ACQUIRE;
                        next_cur.cnt = acq_len;
                        next_cur.acq_act = 1'b1;
                        next_cur.cap_chan = 1'b1;
                    end
                    else
                    begin
                        next_cur.state = APA_CONVERT;
                        next_cur.conv_start = 1'b1;
                        next_cur.cap_chan = 1'b0;
                    end
                end
            end
            APA_PRECHARGE:
            begin
                if (tick)
                begin
                    if (cur.cnt == APA_CNT_ONE)
                    begin
                        next_cur.state = APA_ACQUIRE;
                        next_cur.cnt = acq_len;
                        next_cur.pre_act = 1'b0;
                        next_cur.acq_act = 1'b1;
                        next_cur.pin_oe = 1'b0;
                        next_cur.pin_out = 1'b0;
                        next_cur.cap_vdd = 1'b0;
                        next_cur.cap_vss = 1'b0;
                        next_cur.cap_chan = 1'b1;
                    end
                    else
                    begin
                        next_cur.cnt = cur.cnt - APA_CNT_ONE;
                    end
                end
            end
            APA_ACQUIRE:
            begin
                if (tick)
                begin
                    if (cur.cnt == APA_CNT_ONE)
                    begin
                        next_cur.state = APA_CONVERT;
                        next_cur.acq_act = 1'b0;
                        next_cur.cap_chan = 1'b0;
                        next_cur.conv_start = 1'b1;
                    end
                    else
                    begin
                        next_cur.cnt = cur.cnt - APA_CNT_ONE;
                    end
                end
            end
            APA_CONVERT:
            begin
                if (conv_done)
                begin
                    next_cur.state = APA_IDLE;
                    next_cur.busy = 1'b0;
                end
            end
            default:
            begin
                next_cur = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // ===========================================================
    // Outputs
    // The pin drive ignores pin_direction_control entirely, in every state.
    assign pin_out = cur.pin_out;
    assign pin_oe = cur.pin_oe;
    assign hold_capacitor_to_vdd = cur.cap_vdd;
    assign hold_capacitor_to_vss = cur.cap_vss;
    assign hold_capacitor_to_channel = cur.cap_chan;
    assign precharge_active = cur.pre_act;
    assign acquire_active = cur.acq_act;
    assign conv_start = cur.conv_start;
    assign busy = cur.busy;
endmodule : apa_seq

// *** hdl/apa_pkg.sv ***
// Package: constants and types for the precharge and acquisition sequencer.
// Assumes one converter clock domain; converter clock rate given by a one-cycle enable.
package apa_pkg;
    // ===========================================================
    // Widths and limits
    localparam int APA_PRE_W = 8;
    localparam int APA_ACQ_W = 13;
    localparam logic [12:0] APA_ACQ_MAX = 13'h1fff;
    localparam logic [7:0] APA_PRE_ZERO = 8'h00;
    localparam logic [12:0] APA_ACQ_ZERO = 13'h0000;
    localparam logic [15:0] APA_CNT_ONE = 16'h0001;
    localparam logic [15:0] APA_CNT_ZERO = 16'h0000;
    localparam logic [7:0] APA_DIV_DEFAULT = 8'h00;

    // ===========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        APA_IDLE,
        APA_PRECHARGE,
        APA_ACQUIRE,
        APA_CONVERT
    } apa_state_t;
endpackage : apa_pkg

// *** hdl/apa_clk_div.sv ***
// Converter clock divider: one-cycle enable every div_ratio+1 system clocks.
// Assumes div_ratio is static while a sequence runs.
`timescale 1ns/100ps
module apa_clk_div
    import apa_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Control
    input wire logic [DIV_W-1:0] div_ratio,
    // Enable
    output logic tick
);
    initial
    begin
        if (DIV_W < 1) $error("apa_clk_div: DIV_W must be at least 1");
    end

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } apa_div_t;

    apa_div_t cur;
    apa_div_t next_cur;

    // ===========================================================
    // Divider
    always_comb
    begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (cur.cnt >= div_ratio)
        begin
            next_cur.cnt = '0;
            next_cur.tick = 1'b1;
        end
        else
        begin
            next_cur.cnt = cur.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign tick = cur.tick;
endmodule : apa_clk_div

// *** tb/apa_seq_props.sv ***
// Checker: stage timing and pin relations of apa_seq.
// Assumes binding into apa_seq; one clock domain.
`timescale 1ns/100ps
module apa_seq_props
    import apa_pkg::*;
#(
    parameter int PRE_W = APA_PRE_W,
    parameter int ACQ_W = APA_ACQ_W,
    parameter int DIV_W = 8
)
(
    // Watched ports
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [DIV_W-1:0] conv_clk_div,
    input wire logic go_start,
    input wire logic trigger_start,
    input wire logic restart_start,
    input wire logic [PRE_W-1:0] charge_phase_length,
    input wire logic [ACQ_W-1:0] sampling_window_length,
    input wire logic charge_phase_polarity,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic hold_capacitor_to_vdd,
    input wire logic hold_capacitor_to_vss,
    input wire logic hold_capacitor_to_channel,
    input wire logic precharge_active,
    input wire logic acquire_active,
    input wire logic conv_start,
    input wire logic busy
);
    // ===========================================================
    // Start capture and stage counters
    logic st;
    logic pol_c;
    logic [PRE_W-1:0] pre_c;
    logic [15:0] pcnt;
    logic [15:0] acnt;
    assign st = (go_start | trigger_start | restart_start) & ~busy;
    always_ff @(posedge clk_sys)
    begin
        if (st)
        begin
            pol_c <= charge_phase_polarity;
            pre_c <= charge_phase_length;
        end
        pcnt <= (precharge_active && !srst) ? pcnt + 16'h0001 : 16'h0000;
        acnt <= (acquire_active && !srst) ? acnt + 16'h0001 : 16'h0000;
    end
    // ===========================================================
    // Assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_pre_enter: assert property (st && charge_phase_length != '0 |=> precharge_active)
        else $error("precharge not entered");
    a_acq_direct: assert property (st && charge_phase_length == '0 &&
        sampling_window_length != '0 |=> acquire_active && !precharge_active)
        else $error("acquisition not immediate");
    a_untimed_skip: assert property (st && charge_phase_length == '0 &&
        sampling_window_length == '0 |=> conv_start && !acquire_active)
        else $error("untimed start not handed on");
    a_pin_drive: assert property (precharge_active |-> pin_oe && pin_out == pol_c &&
        hold_capacitor_to_vdd == pol_c && hold_capacitor_to_vss == !pol_c &&
        !hold_capacitor_to_channel) else $error("precharge drive wrong");
    a_pin_release: assert property (acquire_active |-> !pin_oe && hold_capacitor_to_channel)
        else $error("acquisition pin state wrong");
    a_pre_to_acq: assert property ($fell(precharge_active) |-> acquire_active)
        else $error("acquisition not after precharge");
    a_pre_len: assert property ($fell(precharge_active) && conv_clk_div == '0 |->
        pcnt == 16'(pre_c)) else $error("precharge length wrong");
    a_acq_len: assert property ($fell(acquire_active) && conv_clk_div == '0 |->
        acnt == ((sampling_window_length == '0) ? 16'h1fff : 16'(sampling_window_length)))
        else $error("acquisition length wrong");
    a_conv_hand: assert property ($fell(acquire_active) |-> conv_start ##1 !conv_start)
        else $error("conversion handoff wrong");
endmodule : apa_seq_props

bind apa_seq apa_seq_props #(.PRE_W(PRE_W), .ACQ_W(ACQ_W), .DIV_W(DIV_W)) apa_seq_props_inst (
    .clk_sys(clk_sys), .srst(srst), .conv_clk_div(conv_clk_div), .go_start(go_start),
    .trigger_start(trigger_start), .restart_start(restart_start),
    .charge_phase_length(charge_phase_length), .sampling_window_length(sampling_window_length),
    .charge_phase_polarity(charge_phase_polarity), .pin_out(pin_out), .pin_oe(pin_oe),
    .hold_capacitor_to_vdd(hold_capacitor_to_vdd), .hold_capacitor_to_vss(hold_capacitor_to_vss),
    .hold_capacitor_to_channel(hold_capacitor_to_channel), .precharge_active(precharge_active),
    .acquire_active(acquire_active), .conv_start(conv_start), .busy(busy));

// *** tb/apa_sensor.sv ***
// Model: capacitive sensor electrode on the selected channel pin.
// Assumes the sequencer is the only driver of the pin.
`timescale 1ns/100ps
module apa_sensor
(
    // Pin from the sequencer
    input wire logic clk_sys,
    input wire logic pin_out,
    input wire logic pin_oe,
    // Electrode level
    output logic level
);
    logic wobble = 1'b0;
    // Released electrode shows no stable level
    always @(posedge clk_sys) wobble <= ~wobble;
    // Sensor never drives the pin itself
    assign level = pin_oe ? pin_out : wobble;
endmodule : apa_sensor

// *** tb/apa_seq_tb.sv ***
// Testbench: start sequences with expected stage lengths and pin states.
// Assumes apa_seq with default widths and converter clock divider at zero.
`timescale 1ns/100ps
module apa_seq_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [2:0] st = 3'b000;
    logic [7:0] pre = 8'h00;
    logic [12:0] acq = 13'h0000;
    logic pol = 1'b0;
    logic dir = 1'b0;
    logic done = 1'b0;
    logic po, oe, cv, cs, ch, pa, aa, cst, busy, lvl;
    int err_count = 0;
    int checks_done = 0;
    int pc = 0;
    int ac = 0;
    int cc = 0;
    always #10 clk_sys = ~clk_sys;
    apa_seq apa_seq_inst (.clk_sys(clk_sys), .srst(srst), .conv_clk_div(8'h00),
        .go_start(st[0]), .trigger_start(st[1]), .restart_start(st[2]),
        .charge_phase_length(pre), .sampling_window_length(acq), .charge_phase_polarity(pol),
        .pin_direction_control(dir), .conv_done(done), .pin_out(po), .pin_oe(oe),
        .hold_capacitor_to_vdd(cv), .hold_capacitor_to_vss(cs), .hold_capacitor_to_channel(ch),
        .precharge_active(pa), .acquire_active(aa), .conv_start(cst), .busy(busy));
    apa_sensor apa_sensor_inst (.clk_sys(clk_sys), .pin_out(po), .pin_oe(oe), .level(lvl));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // ===========================================================
    // Stage monitor
    always @(negedge clk_sys)
    begin
        pc += pa;
        ac += aa;
        cc += cst;
        if (pa === 1'b1) chk({lvl, oe, cv, cs, ch}, {pol, 1'b1, pol, ~pol, 1'b0});
        if (aa === 1'b1) chk({oe, ch}, 2'b01);
    end
    // One start, a refused start while busy, then conversion done
    task run(input logic [7:0] p, input logic [12:0] a, input logic pl, input int s);
        int n;
        @(posedge clk_sys);
        pre <= p;
        acq <= a;
        pol <= pl;
        dir <= ~pl;
        st[s] <= 1'b1;
        pc = 0;
        ac = 0;
        cc = 0;
        @(posedge clk_sys);
        st <= 3'b000;
        @(posedge clk_sys);
        st <= 3'b111;
        @(posedge clk_sys);
        st <= 3'b000;
        n = 0;
        while (cc == 0 && n < 10000)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        chk(pc, p);
        chk(ac, (a != 0) ? a : ((p != 0) ? 32'h0000_1fff : 32'h0000_0000));
        chk({cc[7:0], busy}, 9'h003);
        @(posedge clk_sys);
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
        @(negedge clk_sys);
        chk(busy, 1'b0);
    endtask : run
    // ===========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        run(8'h02, 13'h0003, 1'b1, 0);
        run(8'h01, 13'h0001, 1'b0, 1);
        run(8'h00, 13'h0004, 1'b1, 2);
        run(8'h00, 13'h0000, 1'b0, 0);
        run(8'h03, 13'h0000, 1'b1, 1);
        run(8'hff, 13'h0001, 1'b0, 2);
        summarize();
    end
    initial
    begin
        #800000;
        err_count++;
        summarize();
    end
endmodule : apa_seq_tb
